// ==== hdl/servo_reference_input_decoder.sv ====
// Servo reference input decoder: analog speed scaling and pulse decoding
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module servo_reference_input_decoder (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Analog reference samples, 0.01 V per LSB, from an on-chip converter
    input  wire logic signed [15:0]       vref_sample,
    input  wire logic                     vref_valid,
    // Pins from the host
    input  wire logic                     reference_pulse_in,
    input  wire logic                     reference_sign_in,
    input  wire logic                     proportional_only_request_n,
    // Commands to the servo loops
    output logic signed [17:0]            speed_cmd,
    output logic                          speed_mode,
    output logic                          loop_p_only,
    output servo_ref_pkg::pos_cmd_t       pos_cmd,
    output logic signed [31:0]            position
);
    import servo_ref_pkg::*;

    ctrl_reg_t          ctrl_r;
    logic [11:0]        scale_r;
    logic [31:0]        prdata_r;
    logic               pready_r;
    logic               pslverr_r;
    logic [1:0]         pin_raw;
    logic [1:0]         pin_filt;
    logic [1:0]         pin_prev_r;
    logic [1:0]         preq_sync_r;
    logic               p_only_r;
    logic               speed_mode_r;
    logic signed [17:0] speed_cmd_r;
    pos_cmd_t           pos_cmd_r;
    logic signed [31:0] position_r;
    div_state_t         div_state_r;
    logic [27:0]        div_num_r;
    logic [11:0]        div_rem_r;
    logic [11:0]        div_den_r;
    logic [4:0]         div_cnt_r;
    logic               div_neg_r;
    logic [12:0]        div_shift;
    logic               div_take;
    logic               apb_done;
    logic               apb_mapped;
    logic [11:0]        scale_wr;
    logic [3:0]         form_base;
    logic               form_neg;
    logic               a_now;
    logic               b_now;
    logic               a_old;
    logic               b_old;
    logic               step_now;
    logic               fwd_now;
    logic [15:0]        vref_mag;

    assign pin_raw = {reference_sign_in, reference_pulse_in};

    // Two-stage sync and optional stability filter on each reference pin
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            logic       meta_r;
            logic       sync_r;
            logic       filt_r;
            logic [2:0] stable_r;
            // A level, not an event, so two flops are enough here
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= pin_raw[gi];
                    sync_r <= meta_r;
                end
            end
            // Filter trades a few clocks of latency for glitch rejection
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    filt_r   <= 1'b0;
                    stable_r <= 3'h0;
                end else if (!ctrl_r.filter_on || sync_r == filt_r) begin
                    filt_r   <= sync_r;
                    stable_r <= 3'h0;
                end else if (stable_r == FILT_LEN - 3'h1) begin
                    filt_r   <= sync_r;
                    stable_r <= 3'h0;
                end else begin
                    stable_r <= stable_r + 3'h1;
                end
            end
            // Transistor on drives the pin high, so the level is used as is
            assign pin_filt[gi] = filt_r;
        end
    endgenerate

    // Previous decoded levels for edge detection
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_prev_r <= 2'b00;
        end else begin
            pin_prev_r <= pin_filt;
        end
    end

    // Form code split into base form and logic sense
    always_comb begin
        form_neg  = (ctrl_r.form >= FORM_NEG_BASE);
        form_base = form_neg ? ctrl_r.form - FORM_NEG_BASE
                             : ctrl_r.form;
        a_now     = pin_filt[0] ^ form_neg;
        b_now     = pin_filt[1] ^ form_neg;
        a_old     = pin_prev_r[0] ^ form_neg;
        b_old     = pin_prev_r[1] ^ form_neg;
    end

    // Edge decode per form; A on pulse pin, B on sign pin
    always_comb begin
        step_now = 1'b0;
        fwd_now  = 1'b0;
        if (ctrl_r.form <= FORM_LAST) begin
            case (form_base)
                FORM_SIGN_PULSE: begin
                    step_now = a_now & ~a_old;
                    fwd_now  = b_now;
                end
                FORM_CW_CCW: begin
                    // Simultaneous CW and CCW edges cancel out
                    step_now = (a_now & ~a_old) ^ (b_now & ~b_old);
                    fwd_now  = a_now & ~a_old;
                end
                FORM_QUAD_X1: begin
                    step_now = a_now & ~a_old & ~(b_now ^ b_old);
                    fwd_now  = a_now ^ b_old;
                end
                FORM_QUAD_X2: begin
                    step_now = (a_now ^ a_old) & ~(b_now ^ b_old);
                    fwd_now  = a_now ^ b_old;
                end
                FORM_QUAD_X4: begin
                    // A double change is an illegal jump and is dropped
                    step_now = (a_now ^ a_old) ^ (b_now ^ b_old);
                    fwd_now  = a_now ^ b_old;
                end
                default: begin
                    step_now = 1'b0;
                    fwd_now  = 1'b0;
                end
            endcase
        end
    end

    // Position counter and step output, only outside analog speed modes
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pos_cmd_r  <= '0;
            position_r <= 32'sh0;
        end else begin
            pos_cmd_r.step    <= step_now & ~speed_mode_r;
            pos_cmd_r.forward <= fwd_now;
            if (step_now && !speed_mode_r) begin
                position_r <= fwd_now ? position_r + 32'sh1
                                      : position_r - 32'sh1;
            end
        end
    end

    // Mode decode and proportional-only request, pin passes two sync flops and one output flop
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            preq_sync_r  <= 2'b11;
            p_only_r     <= 1'b0;
            speed_mode_r <= 1'b0;
        end else begin
            preq_sync_r  <= {preq_sync_r[0], proportional_only_request_n};
            p_only_r     <= ~preq_sync_r[1];
            speed_mode_r <= (ctrl_r.mode == MODE_SPEED_0)
                          | (ctrl_r.mode == MODE_SPEED_4)
                          | (ctrl_r.mode == MODE_SPEED_7)
                          | (ctrl_r.mode == MODE_SPEED_9)
                          | (ctrl_r.mode == MODE_SPEED_A);
        end
    end

    // Speed = |vref| * rated / scale, one quotient bit per clock
    assign vref_mag  = vref_sample[15] ? 16'(-vref_sample)
                                       : 16'(vref_sample);
    assign div_shift = {div_rem_r, div_num_r[27]};
    assign div_take  = (div_shift >= {1'b0, div_den_r});

    // Divider: a new sample is ignored while a division is running
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            div_state_r <= DIV_IDLE;
            div_num_r   <= 28'h0;
            div_rem_r   <= 12'h0;
            div_den_r   <= SCALE_RESET;
            div_cnt_r   <= 5'h0;
            div_neg_r   <= 1'b0;
        end else begin
            case (div_state_r)
                DIV_IDLE: begin
                    if (vref_valid) begin
                        div_num_r   <= {vref_mag, 12'h0};
                        div_rem_r   <= 12'h0;
                        div_den_r   <= scale_r;
                        div_cnt_r   <= 5'h0;
                        div_neg_r   <= vref_sample[15];
                        div_state_r <= DIV_RUN;
                    end
                end
                DIV_RUN: begin
                    div_num_r <= {div_num_r[26:0], div_take};
                    div_rem_r <= div_take
                               ? 12'(div_shift - {1'b0, div_den_r})
                               : div_shift[11:0];
                    div_cnt_r <= div_cnt_r + 5'h1;
                    if (div_cnt_r == DIV_LAST) begin
                        div_state_r <= DIV_IDLE;
                    end
                end
                default: begin
                    div_state_r <= DIV_IDLE;
                end
            endcase
        end
    end

    // Saturated, signed speed command; zero outside analog speed modes
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            speed_cmd_r <= 18'sh0;
        end else if (!speed_mode_r) begin
            speed_cmd_r <= 18'sh0;
        end else if (div_state_r == DIV_RUN && div_cnt_r == DIV_LAST) begin
            if ({div_num_r[26:0], div_take} > {11'h0, SPEED_SAT}) begin
                speed_cmd_r <= div_neg_r ? -$signed({1'b0, SPEED_SAT})
                                         : $signed({1'b0, SPEED_SAT});
            end else begin
                speed_cmd_r <= div_neg_r
                    ? -$signed({1'b0, div_num_r[15:0], div_take})
                    : $signed({1'b0, div_num_r[15:0], div_take});
            end
        end
    end

    // APB: one wait state, writes commit on the edge with pready high
    assign apb_done   = psel & penable & pready_r;
    assign apb_mapped = (paddr == CTRL_OFS) | (paddr == SCALE_OFS)
                      | (paddr == STATUS_OFS) | (paddr == POSITION_OFS)
                      | (paddr == SPEED_OFS);
    // Out-of-range scale writes are clamped rather than refused
    assign scale_wr   = (pwdata[11:0] < SCALE_MIN) ? SCALE_MIN
                      : (pwdata[31:12] != 20'h0 || pwdata[11:0] > SCALE_MAX)
                        ? SCALE_MAX : pwdata[11:0];

    // Register writes
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_r  <= '0;
            scale_r <= SCALE_RESET;
        end else if (apb_done && pwrite) begin
            if (paddr == CTRL_OFS) begin
                ctrl_r.mode      <= pwdata[CTRL_MODE_LSB +: 4];
                ctrl_r.form      <= pwdata[CTRL_FORM_LSB +: 4];
                ctrl_r.filter_on <= pwdata[CTRL_FILTER_BIT];
            end
            if (paddr == SCALE_OFS) begin
                scale_r <= scale_wr;
            end
        end
    end

    // Answer generation and read data
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            pready_r  <= psel & penable & ~pready_r;
            pslverr_r <= psel & penable & ~pready_r & ~apb_mapped;
            prdata_r  <= 32'h0;
            if (psel && penable && !pready_r && !pwrite) begin
                case (paddr)
                    CTRL_OFS:     prdata_r <= {23'h0, ctrl_r};
                    SCALE_OFS:    prdata_r <= {20'h0, scale_r};
                    STATUS_OFS:   prdata_r <= {28'h0, pos_cmd_r.forward,
                                               div_state_r == DIV_RUN,
                                               speed_mode_r, p_only_r};
                    POSITION_OFS: prdata_r <= position_r;
                    SPEED_OFS:    prdata_r <= 32'(speed_cmd_r);
                    default:      prdata_r <= 32'h0;
                endcase
            end
        end
    end

    // Outputs straight from flops
    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign speed_cmd   = speed_cmd_r;
    assign speed_mode  = speed_mode_r;
    assign loop_p_only = p_only_r;
    assign pos_cmd     = pos_cmd_r;
    assign position    = position_r;

endmodule

`default_nettype wire

// ==== shared/servo_ref_pkg.sv ====
// Constants and types shared by the servo reference input decoder
package servo_ref_pkg;

    // APB register byte offsets
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] SCALE_OFS    = 8'h04;
    localparam logic [7:0] STATUS_OFS   = 8'h08;
    localparam logic [7:0] POSITION_OFS = 8'h0C;
    localparam logic [7:0] SPEED_OFS    = 8'h10;

    // Control register field positions
    localparam int CTRL_MODE_LSB   = 0;
    localparam int CTRL_FORM_LSB   = 4;
    localparam int CTRL_FILTER_BIT = 8;

    // Control mode codes that take the analog speed reference
    localparam logic [3:0] MODE_SPEED_0 = 4'h0;
    localparam logic [3:0] MODE_SPEED_4 = 4'h4;
    localparam logic [3:0] MODE_SPEED_7 = 4'h7;
    localparam logic [3:0] MODE_SPEED_9 = 4'h9;
    localparam logic [3:0] MODE_SPEED_A = 4'hA;

    // Pulse form codes; codes 5 to 9 repeat 0 to 4 in negative logic
    localparam logic [3:0] FORM_SIGN_PULSE = 4'h0;
    localparam logic [3:0] FORM_CW_CCW     = 4'h1;
    localparam logic [3:0] FORM_QUAD_X1    = 4'h2;
    localparam logic [3:0] FORM_QUAD_X2    = 4'h3;
    localparam logic [3:0] FORM_QUAD_X4    = 4'h4;
    localparam logic [3:0] FORM_NEG_BASE   = 4'h5;
    localparam logic [3:0] FORM_LAST       = 4'h9;

    // Speed scaling factor, in 0.01 V per rated speed
    localparam logic [11:0] SCALE_MIN   = 12'h096;  // 150
    localparam logic [11:0] SCALE_MAX   = 12'hBB8;  // 3000
    localparam logic [11:0] SCALE_RESET = 12'h258;  // 600: 6 V is rated

    // Speed command: rated speed equals 2^RATED_SHIFT
    localparam int          RATED_SHIFT = 12;
    localparam int          DIV_STEPS   = 28;
    localparam logic [4:0]  DIV_LAST    = 5'h1B;
    localparam logic [16:0] SPEED_SAT   = 17'h1FFFF;

    // Input noise filter length in clocks when the filter is selected
    localparam logic [2:0] FILT_LEN = 3'h4;

    // One decoded position step
    typedef struct packed {
        logic step;     // One-cycle pulse per accepted increment
        logic forward;  // Direction of that increment
    } pos_cmd_t;

    // Software control register
    typedef struct packed {
        logic       filter_on;
        logic [3:0] form;
        logic [3:0] mode;
    } ctrl_reg_t;

    typedef enum logic [0:0] {
        DIV_IDLE = 1'b0,
        DIV_RUN  = 1'b1
    } div_state_t;

endpackage

// ==== tb/servo_ref_sva.sv ====
// Port-level checks for the servo reference input decoder
`timescale 1ns/1ps
`default_nettype none

module servo_ref_sva (
    // Clock and reset
    input wire logic                     sys_clk,
    input wire logic                     sys_rst,
    // APB
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    // Watched inputs
    input wire logic                     vref_valid,
    input wire logic                     proportional_only_request_n,
    // Commands
    input wire logic signed [17:0]       speed_cmd,
    input wire logic                     speed_mode,
    input wire logic                     loop_p_only,
    input wire servo_ref_pkg::pos_cmd_t  pos_cmd,
    input wire logic signed [31:0]       position
);
    import servo_ref_pkg::*;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // Bus answer: one wait state, one-cycle strobe, clean error
    a_apb_answer: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after access phase");
    a_apb_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response carries data");
    // Speed modes ignore pulses; other modes force the speed to zero
    a_no_step_speed: assert property (speed_mode |-> !pos_cmd.step)
        else $error("position step in a speed mode");
    a_speed_zero: assert property (
        !speed_mode && !$past(speed_mode) |-> speed_cmd == 18'h0)
        else $error("speed command not zero outside speed modes");
    // A new speed result always traces back to a sample 29 edges before
    a_speed_cause: assert property (
        $changed(speed_cmd) && speed_mode && $past(speed_mode)
        |-> $past(vref_valid, 29))
        else $error("speed command changed without a sample");
    // Position moves by exactly one per step, in the step's direction
    a_step_moves: assert property (
        pos_cmd.step |-> position ==
        $past(position) + (pos_cmd.forward ? 32'sh1 : -32'sh1))
        else $error("position does not follow step");
    a_pos_hold: assert property (!pos_cmd.step |-> $stable(position))
        else $error("position moved without a step");
    // Proportional-only request follows the synchronised pin
    a_p_only_on: assert property (
        !proportional_only_request_n [*6] |=> loop_p_only)
        else $error("proportional-only not applied");
    a_p_only_off: assert property (
        proportional_only_request_n [*6] |=> !loop_p_only)
        else $error("proportional-only not released");
endmodule
`default_nettype wire

// ==== tb/host_pulse_model.sv ====
// Behavioural host controller driving the reference pins
`timescale 1ns/1ps
`default_nettype none

module host_pulse_model (
    // Pacing clock
    input  wire logic sys_clk,
    // Pins towards the decoder
    output logic      reference_pulse_in,
    output logic      reference_sign_in,
    output logic      proportional_only_request_n
);
    // [1] sign, B or CCW; [0] pulse, A or CW
    logic [1:0] source_output_transistor = 2'h0;
    logic       neg = 1'b0;
    logic       p_req = 1'b0;

    // Open-collector source: transistor on reads as a high level
    assign reference_pulse_in          = source_output_transistor[0];
    assign reference_sign_in           = source_output_transistor[1];
    assign proportional_only_request_n = !p_req;

    // One level pair held for a number of clocks
    task automatic put(input logic [1:0] v, input int hold);
        @(posedge sys_clk);
        source_output_transistor <= v ^ {2{neg}};
        repeat (hold - 1) @(posedge sys_clk);
    endtask

    // Negative logic idles high, so the lines move only in speed mode
    task automatic idle(input logic [3:0] f);
        neg = (f >= 4'h5);
        put(2'h0, 1);
    endtask

    // Raised when an offset leaves the motor creeping at zero speed
    task automatic p_only(input logic on);
        @(posedge sys_clk);
        p_req <= on;
    endtask

    // n reference cycles in the form the decoder was set to
    task automatic send(input logic [3:0] f, input logic fwd,
                        input int n, input int hold);
        logic [3:0] k;
        k = (f >= 4'h5) ? f - 4'h5 : f;
        repeat (n) begin
            case (k)
                4'h0: begin
                    put({fwd, 1'b0}, hold);
                    put({fwd, 1'b1}, hold);
                    put({fwd, 1'b0}, hold);
                end
                4'h1: begin
                    put(fwd ? 2'h1 : 2'h2, hold);
                    put(2'h0, hold);
                end
                default: begin
                    put(fwd ? 2'h1 : 2'h2, hold);
                    put(2'h3, hold);
                    put(fwd ? 2'h2 : 2'h1, hold);
                    put(2'h0, hold);
                end
            endcase
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the servo reference input decoder
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import servo_ref_pkg::*;

    logic               sys_clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic signed [15:0] vref_sample = 16'sh0;
    logic               vref_valid = 1'b0;
    logic               reference_pulse_in;
    logic               reference_sign_in;
    logic               proportional_only_request_n;
    logic signed [17:0] speed_cmd;
    logic               speed_mode;
    logic               loop_p_only;
    pos_cmd_t           pos_cmd;
    logic signed [31:0] position;
    int                 errors = 0;
    int                 total_checks = 0;
    int                 exp_pos = 0;
    logic [31:0]        rd;
    logic               er;

    always #10 sys_clk = ~sys_clk;

    servo_reference_input_decoder u_dut (
        .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .vref_sample, .vref_valid,
        .reference_pulse_in, .reference_sign_in,
        .proportional_only_request_n, .speed_cmd, .speed_mode,
        .loop_p_only, .pos_cmd, .position
    );
    host_pulse_model u_host (
        .sys_clk, .reference_pulse_in, .reference_sign_in,
        .proportional_only_request_n
    );

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors++;
            print_verdict();
        end
    endtask

    task automatic set_ctrl(input logic [3:0] m, input logic [3:0] f,
                            input logic fl);
        apb(1'b1, CTRL_OFS, {23'h0, fl, f, m});
    endtask

    // Rated speed is 4096 counts, truncated, saturating
    function automatic logic [31:0] exp_speed(input int v, input int s);
        int q;
        q = (v < 0 ? -v : v) * (1 << RATED_SHIFT) / s;
        if (q > int'(SPEED_SAT)) q = int'(SPEED_SAT);
        return 32'(v < 0 ? -q : q);
    endfunction

    // Increments per reference cycle for each form code
    function automatic int exp_steps(input logic [3:0] f, input logic fwd,
                                     input int n);
        int m;
        m = (f > 4'h9) ? 0 : (f % 5 == 3) ? 2 : (f % 5 == 4) ? 4 : 1;
        return fwd ? m * n : -m * n;
    endfunction

    task automatic speed_case(input int v, input int s);
        apb(1'b1, SCALE_OFS, 32'(s));
        @(posedge sys_clk);
        vref_sample <= 16'(v);
        vref_valid  <= 1'b1;
        @(posedge sys_clk);
        vref_valid <= 1'b0;
        repeat (32) @(posedge sys_clk);
        check("speed_cmd", 32'(speed_cmd), exp_speed(v, s));
        apb(1'b0, SPEED_OFS, 32'h0);
        check("speed_reg", rd, exp_speed(v, s));
    endtask

    // Pins move to the new idle level only while pulses are ignored
    task automatic pulse_case(input logic [3:0] m, input logic [3:0] f,
                              input logic fwd, input int n,
                              input logic fl);
        logic [31:0] base;
        int          e;
        set_ctrl(MODE_SPEED_0, f, fl);
        u_host.idle(f);
        repeat (8) @(posedge sys_clk);
        set_ctrl(m, f, fl);
        repeat (12) @(posedge sys_clk);
        base = position;
        e = (m == MODE_SPEED_0) ? 0 : exp_steps(f, fwd, n);
        u_host.send(f, fwd, n, fl ? 8 : 4);
        repeat (12) @(posedge sys_clk);
        check("position", position - base, 32'(e));
        exp_pos += e;
    endtask

    initial begin
        void'($urandom(32'h9273));
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        check("position_rst", position, 32'h0);
        apb(1'b0, CTRL_OFS, 32'h0);
        check("ctrl_rst", rd, 32'h0);
        apb(1'b0, SCALE_OFS, 32'h0);
        check("scale_rst", rd, 32'(SCALE_RESET));
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped", {rd[30:0], er}, 32'h1);
        // Scale writes outside the range are clamped
        apb(1'b1, SCALE_OFS, 32'h64);
        apb(1'b0, SCALE_OFS, 32'h0);
        check("scale_min", rd, 32'h96);
        apb(1'b1, SCALE_OFS, 32'hFA0);
        apb(1'b0, SCALE_OFS, 32'h0);
        check("scale_max", rd, 32'hBB8);
        // Every mode code; only the analog speed modes select speed
        for (int m = 0; m < 16; m++) begin
            set_ctrl(4'(m), 4'h0, 1'b0);
            repeat (3) @(posedge sys_clk);
            check("speed_mode", 32'(speed_mode),
                  32'(m inside {0, 4, 7, 9, 10}));
        end
        set_ctrl(MODE_SPEED_0, 4'h0, 1'b0);
        speed_case(600, 600);
        speed_case(-300, 600);
        speed_case(32767, 150);
        speed_case(-32768, 3000);
        repeat (6) begin
            speed_case(int'($urandom_range(2400)) - 1200,
                       int'($urandom_range(3000, 150)));
        end
        set_ctrl(4'h1, 4'h0, 1'b0);
        repeat (3) @(posedge sys_clk);
        check("speed_off", 32'(speed_cmd), 32'h0);
        // Proportional-only request on and off
        u_host.p_only(1'b1);
        repeat (8) @(posedge sys_clk);
        check("p_only_on", 32'(loop_p_only), 32'h1);
        apb(1'b0, STATUS_OFS, 32'h0);
        check("status_p", 32'(rd[0]), 32'h1);
        check("status_mode", 32'(rd[2:1]), 32'h0);
        u_host.p_only(1'b0);
        repeat (8) @(posedge sys_clk);
        check("p_only_off", 32'(loop_p_only), 32'h0);
        // Every pulse form both ways; lines settled long before
        for (int f = 0; f < 10; f++) begin
            pulse_case(4'h1, 4'(f), 1'b1, int'($urandom_range(3, 1)),
                       1'b0);
            pulse_case(4'h1, 4'(f), 1'b0, int'($urandom_range(3, 1)),
                       1'b0);
        end
        pulse_case(4'h1, 4'hB, 1'b1, 2, 1'b0);
        pulse_case(4'h1, FORM_QUAD_X4, 1'b0, 2, 1'b1);
        // A two-clock glitch counts only while the filter is off
        for (int fl = 0; fl < 2; fl++) begin
            set_ctrl(4'h1, FORM_SIGN_PULSE, 1'(fl));
            u_host.put(2'h2, 12);
            u_host.put(2'h3, 2);
            u_host.put(2'h2, 12);
            exp_pos += 1 - fl;
            check("glitch", position, 32'(exp_pos));
        end
        pulse_case(MODE_SPEED_0, FORM_SIGN_PULSE, 1'b1, 2, 1'b0);
        // Read-only position ignores writes
        apb(1'b1, POSITION_OFS, 32'hFFFF);
        apb(1'b0, POSITION_OFS, 32'h0);
        check("position_reg", rd, 32'(exp_pos));
        print_verdict();
    end
endmodule

bind servo_reference_input_decoder servo_ref_sva u_sva (
    .sys_clk, .sys_rst, .psel, .penable, .prdata, .pready, .pslverr,
    .vref_valid, .proportional_only_request_n, .speed_cmd, .speed_mode,
    .loop_p_only, .pos_cmd, .position
);
`default_nettype wire
